/* File: src/ssm_top.sv */
// start statistics, histories, distortion scheduling, frequency and imbalance
// assumes all inputs are synchronous to MCLK_I from the measurement front end
// Contract
// - estimated speed is passed on only during linear-speed ramp start or stop
// - outside ramp modes speed reads zero, or 100 percent at full speed
// - start duration of each completed (not aborted) start kept in five-entry fifo history
// - peak average rms current of each completed (not aborted) start kept in five-entry fifo
// - total starts counter starts at zero, counts each start up to 30000 and holds there, never clears
// - counter counts only once thyristor gating begins, not on prestart fault
// - distortion for three voltages, three currents and their two averages
// - distortion signals visited round-robin, one per power cycle
// - current distortion results forced to zero while motor not running
// - line frequency reads zero after power up until first valid measurement
// - line frequency holds last value when three-phase supply is lost
// - current imbalance is largest deviation from mean over the mean
// - voltage unbalance is largest deviation from mean over the mean
`timescale 1ns/100ps
`include "ssm_map.svh"
module ssm_top
  import ssm_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic RAMP_MODE_I,
  input wire logic AT_SPEED_I,
  input wire logic [6:0] SPEED_EST_I,
  input wire logic START_CMD_I,
  input wire logic GATING_I,
  input wire logic START_DONE_I,
  input wire logic START_ABORT_I,
  input wire logic MOTOR_RUN_I,
  input wire logic [15:0] I_AVG_RMS_I,
  input wire logic [15:0] I_RMS_A_I,
  input wire logic [15:0] I_RMS_B_I,
  input wire logic [15:0] I_RMS_C_I,
  input wire logic [15:0] V_RMS_A_I,
  input wire logic [15:0] V_RMS_B_I,
  input wire logic [15:0] V_RMS_C_I,
  input wire logic CYCLE_I,
  input wire logic [15:0] THD_VAL_I,
  input wire logic THD_VAL_VLD_I,
  input wire logic FREQ_VLD_I,
  input wire logic [6:0] FREQ_I,
  output logic [6:0] SPEED_O,
  output logic [2:0] THD_SEL_O,
  output logic [15:0] THD_V_O [3],
  output logic [15:0] THD_I_O [3],
  output logic [15:0] THD_V_AVG_O,
  output logic [15:0] THD_I_AVG_O,
  output logic [15:0] START_TIME_O [5],
  output logic [15:0] PEAK_CUR_O [5],
  output logic [15:0] TOTAL_STARTS_O,
  output logic [6:0] LINE_FREQ_O,
  output logic [15:0] CUR_IMBAL_O,
  output logic [15:0] VOLT_UNBAL_O
);

  //////////////////////////////////////////////////////////////////////
  // shared arithmetic: percent of largest deviation from mean
  function automatic ssm_word_t imbal(input ssm_word_t a, input ssm_word_t b, input ssm_word_t c);
    logic [17:0] sum;
    logic [17:0] mean3;
    logic [17:0] da;
    logic [17:0] db;
    logic [17:0] dc;
    logic [17:0] dmax;
    logic [24:0] num;
    sum = 18'(a) + 18'(b) + 18'(c);
    mean3 = sum;
    da = (18'(a) * 18'h0_0003 > mean3) ? 18'(a) * 18'h0_0003 - mean3 : mean3 - 18'(a) * 18'h0_0003;
    db = (18'(b) * 18'h0_0003 > mean3) ? 18'(b) * 18'h0_0003 - mean3 : mean3 - 18'(b) * 18'h0_0003;
    dc = (18'(c) * 18'h0_0003 > mean3) ? 18'(c) * 18'h0_0003 - mean3 : mean3 - 18'(c) * 18'h0_0003;
    dmax = (da > db) ? da : db;
    dmax = (dc > dmax) ? dc : dmax;
    // deviation and mean both scaled by three, so the ratio is exact
    num = 25'(dmax) * 25'(`SSM_PCT_SCALE);
    if (sum == 18'h0_0000) begin
      imbal = 16'h0000;
    end else begin
      imbal = 16'(num / 25'(sum));
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // start tracking and statistics
  ssm_start_t st_reg, st_next;
  logic [15:0] dur_reg, dur_next;
  logic [15:0] peak_reg, peak_next;
  logic [26:0] tick_reg, tick_next;
  logic [15:0] hist_t_reg [5], hist_t_next [5];
  logic [15:0] hist_p_reg [5], hist_p_next [5];
  logic [15:0] total_reg, total_next;
  logic counted_reg, counted_next;
  logic record;

  always_comb begin
    st_next = st_reg;
    dur_next = dur_reg;
    peak_next = peak_reg;
    tick_next = tick_reg;
    hist_t_next = hist_t_reg;
    hist_p_next = hist_p_reg;
    total_next = total_reg;
    counted_next = counted_reg;
    record = 1'b0;
    unique case (st_reg)
      SSM_IDLE: begin
        if (START_CMD_I) begin
          st_next = SSM_STARTING;
          dur_next = 16'h0000;
          peak_next = 16'h0000;
          tick_next = 27'h000_0000;
          counted_next = 1'b0;
        end
      end
      SSM_STARTING: begin
        // a prestart abort before gating leaves the counter untouched
        if (GATING_I && !counted_reg && total_reg != `SSM_TSTART_MAX) begin
          total_next = total_reg + 16'h0001;
          counted_next = 1'b1;
        end else if (GATING_I) begin
          counted_next = 1'b1;
        end
        if (I_AVG_RMS_I > peak_reg) begin
          peak_next = I_AVG_RMS_I;
        end
        if (tick_reg == 27'(`SSM_TICK_CYCLES - 1)) begin
          tick_next = 27'h000_0000;
          if (dur_reg != `SSM_DUR_MAX) begin
            dur_next = dur_reg + 16'h0001;
          end
        end else begin
          tick_next = tick_reg + 27'h000_0001;
        end
        if (START_ABORT_I) begin
          st_next = SSM_IDLE;
        end else if (START_DONE_I) begin
          st_next = SSM_RUNNING;
          record = 1'b1;
        end
      end
      SSM_RUNNING: begin
        if (!MOTOR_RUN_I) begin
          st_next = SSM_IDLE;
        end
      end
      default: st_next = SSM_IDLE;
    endcase
    if (record) begin
      for (int k = 4; k > 0; k--) begin
        hist_t_next[k] = hist_t_reg[k-1];
        hist_p_next[k] = hist_p_reg[k-1];
      end
      hist_t_next[0] = dur_reg;
      hist_p_next[0] = peak_next;
    end
  end

  // total count has no clear path; only the power-on reset zeroes it
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_reg <= SSM_IDLE;
      dur_reg <= 16'h0000;
      peak_reg <= 16'h0000;
      tick_reg <= 27'h000_0000;
      hist_t_reg <= '{default: 16'h0000};
      hist_p_reg <= '{default: 16'h0000};
      total_reg <= 16'h0000;
      counted_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      dur_reg <= dur_next;
      peak_reg <= peak_next;
      tick_reg <= tick_next;
      hist_t_reg <= hist_t_next;
      hist_p_reg <= hist_p_next;
      total_reg <= total_next;
      counted_reg <= counted_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // speed, frequency, distortion round-robin, imbalance
  logic [6:0] speed_reg, speed_next;
  logic [6:0] freq_reg, freq_next;
  logic [2:0] sel_reg, sel_next;
  logic [15:0] thd_reg [6], thd_next [6];
  logic [15:0] ci_reg, ci_next;
  logic [15:0] vu_reg, vu_next;
  logic [17:0] vsum;
  logic [17:0] isum;

  always_comb begin
    speed_next = 7'h00;
    if (RAMP_MODE_I) begin
      speed_next = SPEED_EST_I;
    end else if (AT_SPEED_I) begin
      speed_next = `SSM_SPEED_FULL;
    end
    freq_next = freq_reg;
    if (FREQ_VLD_I) begin
      freq_next = FREQ_I;
    end
    sel_next = sel_reg;
    thd_next = thd_reg;
    if (THD_VAL_VLD_I) begin
      thd_next[sel_reg] = THD_VAL_I;
    end
    if (CYCLE_I) begin
      sel_next = (sel_reg == 3'(`SSM_THD_SIGNALS - 1)) ? 3'h0 : sel_reg + 3'h1;
    end
    if (!MOTOR_RUN_I) begin
      thd_next[3] = 16'h0000;
      thd_next[4] = 16'h0000;
      thd_next[5] = 16'h0000;
    end
    ci_next = imbal(I_RMS_A_I, I_RMS_B_I, I_RMS_C_I);
    vu_next = imbal(V_RMS_A_I, V_RMS_B_I, V_RMS_C_I);
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      speed_reg <= 7'h00;
      freq_reg <= 7'h00;
      sel_reg <= 3'h0;
      thd_reg <= '{default: 16'h0000};
      ci_reg <= 16'h0000;
      vu_reg <= 16'h0000;
    end else begin
      speed_reg <= speed_next;
      freq_reg <= freq_next;
      sel_reg <= sel_next;
      thd_reg <= thd_next;
      ci_reg <= ci_next;
      vu_reg <= vu_next;
    end
  end

  // averages are combinational from stored results; current side already zeroed
  assign vsum = 18'(thd_reg[0]) + 18'(thd_reg[1]) + 18'(thd_reg[2]);
  assign isum = 18'(thd_reg[3]) + 18'(thd_reg[4]) + 18'(thd_reg[5]);

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign SPEED_O = speed_reg;
  assign THD_SEL_O = sel_reg;
  assign THD_V_O = '{thd_reg[0], thd_reg[1], thd_reg[2]};
  assign THD_I_O = '{thd_reg[3], thd_reg[4], thd_reg[5]};
  assign THD_V_AVG_O = 16'(vsum / 18'h0_0003);
  assign THD_I_AVG_O = 16'(isum / 18'h0_0003);
  assign START_TIME_O = hist_t_reg;
  assign PEAK_CUR_O = hist_p_reg;
  assign TOTAL_STARTS_O = total_reg;
  assign LINE_FREQ_O = freq_reg;
  assign CUR_IMBAL_O = ci_reg;
  assign VOLT_UNBAL_O = vu_reg;

  //////////////////////////////////////////////////////////////////////
  // assertions
  a_speed_ramp: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    RAMP_MODE_I |=> SPEED_O == $past(SPEED_EST_I)) else $error("speed not passed in ramp");
  a_speed_idle: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    !RAMP_MODE_I |=> SPEED_O == ($past(AT_SPEED_I) ? 7'h64 : 7'h00)) else $error("speed wrong outside ramp");
  a_hist_shift: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    record |=> START_TIME_O[1] == $past(hist_t_reg[0]) && PEAK_CUR_O[4] == $past(hist_p_reg[3]))
    else $error("history not shifted");
  a_hist_new: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    record |=> START_TIME_O[0] == $past(dur_reg)) else $error("newest duration missing");
  a_hist_hold: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    !record |=> $stable(PEAK_CUR_O[0])) else $error("peak history moved without record");
  a_total_mono: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    TOTAL_STARTS_O == $past(TOTAL_STARTS_O) || TOTAL_STARTS_O == $past(TOTAL_STARTS_O) + 16'h0001)
    else $error("total starts jumped");
  a_total_gate: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    !GATING_I |=> $stable(TOTAL_STARTS_O)) else $error("count without gating");
  a_rr_step: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    CYCLE_I && THD_SEL_O == 3'h5 |=> THD_SEL_O == 3'h0) else $error("round robin no wrap");
  a_thd_zero: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    !MOTOR_RUN_I |=> THD_I_O[0] == 16'h0000 && THD_I_AVG_O == 16'h0000) else $error("current thd not zero");
  a_freq_hold: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    !FREQ_VLD_I |=> $stable(LINE_FREQ_O)) else $error("frequency not held");
  c_start_rec: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I) record);
  c_abort: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I) st_reg == SSM_STARTING && START_ABORT_I);
  c_rr_wrap: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I) CYCLE_I && THD_SEL_O == 3'h5);
endmodule

/* File: src/ssm_map.svh */
// constants for the start statistics and metering block
// assumes inclusion by the block's top module only
`ifndef SSM_MAP_SVH
`define SSM_MAP_SVH
`define SSM_HIST_DEPTH 5
`define SSM_THD_SIGNALS 6
`define SSM_SPEED_FULL 7'h64
`define SSM_PCT_SCALE 16'h0064
`define SSM_TSTART_MAX 16'h7530
`define SSM_DUR_MAX 16'h03E8
`define SSM_TICK_NS 1000000000
`define SSM_CLK_NS 10
`define SSM_TICK_CYCLES (`SSM_TICK_NS / `SSM_CLK_NS)
`endif

/* File: src/ssm_pkg.sv */
// types for the start statistics and metering block
// assumes ssm_map.svh is on the include path
package ssm_pkg;
  typedef enum logic [1:0] {SSM_IDLE, SSM_STARTING, SSM_RUNNING} ssm_start_t;
  typedef logic [15:0] ssm_word_t;
endpackage

/* File: dv/ssm_front_model.sv */
// measurement front end model: power-cycle marks and distortion results
// assumes the block's selector is fed back and inputs change 1 ns after the edge
`timescale 1ns/100ps
module ssm_front_model
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] sel_i,
  output logic cycle_o,
  output logic [15:0] val_o,
  output logic vld_o
);
  logic [2:0] cnt;
  logic [15:0] last;
  ////////////////////////////////////////////////////////////////////////
  // one power cycle every 8 clocks, shortened so a full round stays brief
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 3'h0;
      cycle_o <= 1'b0;
      vld_o <= 1'b0;
      val_o <= 16'h0000;
      last <= 16'h0000;
    end else begin
      cnt <= cnt + 3'h1;
      cycle_o <= #1 (cnt == 3'h7);
      vld_o <= #1 (cnt == 3'h7);
      // result tied to the signal selected at that moment
      last <= (cnt == 3'h7) ? 16'h0100 + {13'h0, sel_i} : last;
      // released data shows the inverse, so a stale value never matches
      val_o <= #1 (cnt == 3'h7) ? 16'h0100 + {13'h0, sel_i} : ~last;
    end
  end
endmodule

/* File: dv/ssm_top_tb.sv */
// self-checking bench for the start statistics and metering block
// assumes one clock, registered outputs one cycle after their cause
`timescale 1ns/100ps
module ssm_top_tb;
  import ssm_pkg::*;
  typedef struct {int c; logic [15:0] v;} ssm_note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ramp = 1'b0, at_spd = 1'b0, cmd = 1'b0, gate = 1'b0, done = 1'b0, abrt = 1'b0, run = 1'b0, fvld = 1'b0;
  logic [6:0] est = 7'h00, fin = 7'h00, speed, freq;
  logic [15:0] iavg = 16'h0000, ia = 16'h0000, ib = 16'h0000, ic = 16'h0000;
  logic [15:0] va = 16'h0000, vb = 16'h0000, vc = 16'h0000;
  logic cyc, tvld;
  logic [2:0] sel;
  logic [15:0] tval, thd_va, thd_ia, total, cimb, vunb, p, p_prev, p_old;
  logic [15:0] thd_v [3];
  logic [15:0] thd_i [3];
  logic [15:0] st_time [5];
  logic [15:0] peak [5];
  int n_fail = 0, n_checks = 0, seed = 32'h61e99a27, k;
  ssm_note_t q[$];
  ssm_note_t cur;
  event chk_ev;
  string nm [15] = '{"speed", "total", "time0", "peak0", "peak1", "freq", "cimb", "vunb", "thd_i0", "thd_vavg",
    "thd_iavg", "peak4", "thd_v0", "thd_v2", "thd_i2"};
  always #5 clk = ~clk;
  ssm_front_model u_front (.clk_i(clk), .rst_n_i(rst_n), .sel_i(sel), .cycle_o(cyc), .val_o(tval), .vld_o(tvld));
  ssm_top u_dut (.MCLK_I(clk), .ARST_N_I(rst_n), .RAMP_MODE_I(ramp), .AT_SPEED_I(at_spd), .SPEED_EST_I(est),
    .START_CMD_I(cmd), .GATING_I(gate), .START_DONE_I(done), .START_ABORT_I(abrt), .MOTOR_RUN_I(run),
    .I_AVG_RMS_I(iavg), .I_RMS_A_I(ia), .I_RMS_B_I(ib), .I_RMS_C_I(ic), .V_RMS_A_I(va), .V_RMS_B_I(vb),
    .V_RMS_C_I(vc), .CYCLE_I(cyc), .THD_VAL_I(tval), .THD_VAL_VLD_I(tvld), .FREQ_VLD_I(fvld), .FREQ_I(fin),
    .SPEED_O(speed), .THD_SEL_O(sel), .THD_V_O(thd_v), .THD_I_O(thd_i), .THD_V_AVG_O(thd_va),
    .THD_I_AVG_O(thd_ia), .START_TIME_O(st_time), .PEAK_CUR_O(peak), .TOTAL_STARTS_O(total),
    .LINE_FREQ_O(freq), .CUR_IMBAL_O(cimb), .VOLT_UNBAL_O(vunb));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] obs(input int c);
    case (c)
      0: return {9'h000, speed};
      1: return total;
      2: return st_time[0];
      3: return peak[0];
      4: return peak[1];
      5: return {9'h000, freq};
      6: return cimb;
      7: return vunb;
      8: return thd_i[0];
      9: return thd_va;
      10: return thd_ia;
      11: return peak[4];
      12: return thd_v[0];
      13: return thd_v[2];
      default: return thd_i[2];
    endcase
  endfunction
  task automatic chk(input int c, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm[c], exp, seen);
    end
  endtask
  // monitor takes notes oldest first once the driver says results stand
  always @(chk_ev) begin
    while (q.size() > 0) begin
      cur = q.pop_front();
      chk(cur.c, obs(cur.c), cur.v);
    end
  end
  task automatic note(input int c, input logic [15:0] v);
    q.push_back('{c, v});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // short start: duration stays below one second tick
  task automatic start_run(input logic [15:0] pk);
    cmd = 1'b1; run = 1'b1; tick(1);
    cmd = 1'b0; gate = 1'b1; iavg = pk; tick(1);
    gate = 1'b0; iavg = pk >> 1; done = 1'b1; tick(1);
    done = 1'b0; run = 1'b0; tick(1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    n_fail++;
    conclude();
  end
  initial begin
    tick(3);
    rst_n = 1'b1;
    tick(1);
    note(0, 16'h0000); note(1, 16'h0000); note(5, 16'h0000); -> chk_ev;
    for (k = 0; k < 4; k++) begin
      ramp = 1'b1; est = 7'($unsigned($random(seed)) % 101); tick(1);
      note(0, {9'h000, est}); -> chk_ev;
    end
    ramp = 1'b0; at_spd = 1'b1; tick(1);
    note(0, 16'h0064); -> chk_ev;
    at_spd = 1'b0; est = 7'h33; tick(1);
    note(0, 16'h0000); -> chk_ev;
    fvld = 1'b1; fin = 7'h3C; tick(1);
    fvld = 1'b0; fin = 7'h32; tick(2);
    note(5, 16'h003C); -> chk_ev;
    p_prev = 16'h0000;
    for (k = 1; k <= 6; k++) begin
      p = 16'h03E8 + 16'($unsigned($random(seed)) & 32'h1FFF);
      start_run(p);
      note(1, 16'(k)); note(2, 16'h0000); note(3, p); note(4, p_prev); -> chk_ev;
      if (k == 2) p_old = p;
      p_prev = p;
    end
    note(11, p_old); -> chk_ev;
    cmd = 1'b1; tick(1);
    cmd = 1'b0; abrt = 1'b1; tick(1);
    abrt = 1'b0; tick(1);
    note(1, 16'h0006); note(3, p); -> chk_ev;
    ia = 16'h0050; ib = 16'h0064; ic = 16'h0078; va = 16'h00C8; vb = 16'h012C; vc = 16'h00FA;
    tick(2);
    note(6, 16'h0014); note(7, 16'h0014); -> chk_ev;
    run = 1'b1;
    for (k = 0; k < 200 && thd_ia !== 16'h0104; k++) tick(1);
    if (k == 200) n_fail++;
    note(12, 16'h0100); note(13, 16'h0102); note(14, 16'h0105);
    note(8, 16'h0103); note(9, 16'h0101); note(10, 16'h0104); -> chk_ev;
    run = 1'b0; tick(2);
    note(14, 16'h0000); note(12, 16'h0100);
    note(8, 16'h0000); note(10, 16'h0000); note(9, 16'h0101); -> chk_ev;
    tick(1);
    conclude();
  end
endmodule
